//--- inc/irq_src_pkg.sv
/*
  Constants and types for the interrupt source logic: status bit
  positions, pin routing masks, delay timer length.
  Assumes a single 100 MHz clock domain.
*/
package irq_src_pkg;
  // ****************************************
  // Widths and clock
  // ****************************************
  localparam int HV_PINS = 8;
  localparam int FIX_FLAGS = 16;
  localparam int CLK_PERIOD_NS = 10;
  // Interrupt delay time in microseconds, cycles derived
  localparam int INT_DELAY_US = 128;
  localparam int INT_DELAY_CYC = (INT_DELAY_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // Fixed flag positions
  // ****************************************
  localparam int B_WDOG = 0;
  localparam int B_SERIAL = 1;
  localparam int B_OTEMP = 2;
  localparam int B_PWRON = 3;
  localparam int B_OVSD = 4;
  localparam int B_MAIN_UV = 5;
  localparam int B_AUX_UV = 6;
  localparam int B_AUX_OV = 7;
  localparam int B_BATT_UV = 8;
  localparam int B_BATT_OV = 9;
  localparam int B_SWITCH = 10;
  localparam int B_CAN_WAKE = 11;
  localparam int B_CAN_FAIL = 12;
  localparam int B_LIN_A = 13;
  localparam int B_LIN_B = 14;
  localparam int B_SILENCE = 15;
  localparam int B_PN_ERR = 16;
  localparam int SYS_FLAGS = 17;

  // Sources without an enable bit
  localparam logic [SYS_FLAGS-1:0] ALWAYS_ON_MASK = 17'h10019;
  // Sources that also drive the critical pin
  localparam logic [SYS_FLAGS-1:0] CRITICAL_MASK = 17'h00734;
  localparam logic [SYS_FLAGS-1:0] FLAGS_RESET = 17'h00000;

  typedef enum logic [2:0] {
    DLY_IDLE = 3'h1,
    DLY_RUN = 3'h2,
    DLY_HOLD = 3'h4
  } dly_state_t;
endpackage

//--- verilog/flag_bank.sv
/*
  Bank of sticky flags: set on enabled event, cleared by write-one.
  Assumes events and clear strobes are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] enable_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_nxt;

  // ****************************************
  // Per-bit set/clear, set wins over clear
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always_comb
      begin
        flags_nxt[i] = flags[i] & ~clear_in[i]; // [RULE23]
        if (event_in[i] && enable_in[i])
        begin
          flags_nxt[i] = 1'b1; // [RULE27]
        end
      end
    end
  endgenerate

  // Register flags
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      flags <= '0;
    end
    else
    begin
      flags <= flags_nxt;
    end
  end

  chk_clear_one: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE23]
    (clear_in != '0 && (event_in & enable_in & clear_in) == '0)
      |=> ((flags & $past(clear_in)) == '0))
    else $error("written-one flag not cleared");
  chk_set_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE27]
    ((event_in & enable_in) != '0) |=> ((flags & $past(event_in & enable_in)) != '0))
    else $error("enabled event not latched");
endmodule

//--- verilog/int_delay_timer.sv
/*
  Interrupt delay timer: runs after a clear, stopped by reset pin low.
  Assumes start and stop are synchronous single-cycle or level inputs.
*/
`timescale 1ns/1ps
module int_delay_timer
  import irq_src_pkg::*;
#(
  parameter int DELAY_CYC = INT_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  input wire logic start,
  input wire logic stop,
  output logic running
);
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  dly_state_t state_r, state_nxt;
  logic [CW-1:0] count_r, count_nxt;

  // Timer state and count
  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      DLY_IDLE:
      begin
        if (start && !stop)
        begin
          state_nxt = DLY_RUN;
          count_nxt = '0;
        end
      end
      DLY_RUN:
      begin
        if (stop)
        begin
          state_nxt = DLY_IDLE; // [RULE25]
        end
        else if (start)
        begin
          count_nxt = '0;
        end
        else if (count_r == LAST)
        begin
          state_nxt = DLY_IDLE;
        end
        else
        begin
          count_nxt = count_r + 1'b1;
        end
      end
      default:
      begin
        state_nxt = DLY_IDLE;
      end
    endcase
  end

  // Register timer
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r <= DLY_IDLE;
      count_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign running = (state_r == DLY_RUN);

  chk_stop_timer: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE25]
    stop |=> !running)
    else $error("delay timer not stopped by reset pin");
endmodule

//--- verilog/irq_source_logic.sv
/*
  Interrupt source logic: qualifies event sources, latches status
  flags, drives two active-low interrupt pins and holds bus receive
  pins low after bus wake-ups.
  Assumes all inputs synchronous to sys_clk; clear strobes are
  one-cycle write-one pulses from the serial register interface.
*/
`timescale 1ns/1ps

// Overview of operation
// RULE1: Watchdog, partial-net error, power-on, overvoltage shutdown cannot be masked.
// RULE2: Bus wake-up drives its receive pin low until its flag clears.
// RULE3: CAN fail flag when CAN supply or CAN fault status set; first pin.
// RULE4: CAN wake flag on wake event outside Active mode; first pin.
// RULE5: CAN silence flag on silence timeout; first pin.
// RULE6: Each LIN wake flag on wake outside Active mode; first pin.
// RULE7: Watchdog fail flag on overflow in Timeout mode; first pin.
// RULE8: Overflow while watchdog flag pending requests a reset.
// RULE9: Overtemperature warning drives both pins.
// RULE10: Partial-net error frame sets flag on first pin.
// RULE11: Leaving Off mode sets power-on flag; first pin.
// RULE12: Illegal codes, locked write or bad clock count set serial flag.
// RULE13: Main regulator undervoltage on both pins, not in Sleep.
// RULE14: Secondary supply undervoltage on first pin.
// RULE15: Secondary supply overvoltage on first pin.
// RULE16: Battery monitor undervoltage on both pins.
// RULE17: Battery monitor overvoltage on both pins.
// RULE18: Overvoltage shutdown into Overload sets flag on both pins.
// RULE19: Any switcher state change sets flag on both pins.
// RULE20: Open load with driver active sets per-pin flag; first pin.
// RULE21: Short with driver active sets per-pin flag; first pin.
// RULE22: Wake-input edges set per-pin rise and fall flags; first pin.
// RULE23: Write one clears a flag; zero leaves it; many at once.
// RULE24: Pins low while anything pending; high once all clear.
// RULE25: Clear releases first pin for delay; critical pin immediate.
// RULE26: Any interrupt in low-power mode requests a wake-up.
// RULE27: Flags latch only when enabled or always-on, held until cleared.
module irq_source_logic
  import irq_src_pkg::*;
#(
  parameter int NUM_HV = irq_src_pkg::HV_PINS,
  parameter int DELAY_CYC = irq_src_pkg::INT_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reset_out_n,
  input wire logic low_power_mode,
  input wire logic sleep_mode,
  input wire logic can_active,
  input wire logic lin_a_active,
  input wire logic lin_b_active,
  input wire logic can_wake_evt,
  input wire logic lin_a_wake_evt,
  input wire logic lin_b_wake_evt,
  input wire logic can_supply_stat,
  input wire logic can_fault_stat,
  input wire logic can_silence_evt,
  input wire logic watchdog_overflow,
  input wire logic watchdog_timeout_mode,
  input wire logic overtemp_evt,
  input wire logic partial_net_err_evt,
  input wire logic off_mode_exit,
  input wire logic bad_watchdog_mode_code,
  input wire logic bad_watchdog_period_code,
  input wire logic bad_op_mode_code,
  input wire logic locked_reg_write,
  input wire logic serial_frame_done,
  input wire logic [5:0] serial_bit_count,
  input wire logic main_reg_under,
  input wire logic main_reg_reset_thresh,
  input wire logic aux_supply_under,
  input wire logic aux_supply_over,
  input wire logic batt_mon_under,
  input wire logic batt_mon_over,
  input wire logic overload_entry,
  input wire logic switcher_state,
  input wire logic [NUM_HV-1:0] hv_driver_active,
  input wire logic [NUM_HV-1:0] hv_wake_input,
  input wire logic [NUM_HV-1:0] hv_open_load_evt,
  input wire logic [NUM_HV-1:0] hv_short_evt,
  input wire logic [NUM_HV-1:0] hv_rise_evt,
  input wire logic [NUM_HV-1:0] hv_fall_evt,
  input wire logic [SYS_FLAGS-1:0] sys_enable,
  input wire logic [NUM_HV-1:0] hv_open_load_en,
  input wire logic [NUM_HV-1:0] hv_short_en,
  input wire logic [NUM_HV-1:0] hv_rise_en,
  input wire logic [NUM_HV-1:0] hv_fall_en,
  input wire logic [SYS_FLAGS-1:0] sys_clear,
  input wire logic [NUM_HV-1:0] hv_open_load_clear,
  input wire logic [NUM_HV-1:0] hv_short_clear,
  input wire logic [NUM_HV-1:0] hv_rise_clear,
  input wire logic [NUM_HV-1:0] hv_fall_clear,
  output logic [SYS_FLAGS-1:0] sys_flags_out,
  output logic [NUM_HV-1:0] hv_pin_open_load_flag,
  output logic [NUM_HV-1:0] hv_pin_short_flag,
  output logic [NUM_HV-1:0] hv_pin_rise_flag,
  output logic [NUM_HV-1:0] hv_pin_fall_flag,
  output logic irq_out_all_n,
  output logic irq_out_critical_n,
  output logic can_rx_pin_low,
  output logic lin_a_rx_pin_low,
  output logic lin_b_rx_pin_low,
  output logic watchdog_reset_req,
  output logic wake_req
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_r, rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ****************************************
  // Source qualification
  // ****************************************
  logic [SYS_FLAGS-1:0] sys_evt, sys_en_eff, sys_flags;
  logic [NUM_HV-1:0] ol_flags, sc_flags, re_flags, fe_flags;
  logic switcher_prev_r, can_fail_prev_r, bad_count;
  logic [NUM_HV-1:0] ol_evt, sc_evt, re_evt, fe_evt;

  // Previous values for change and edge detection
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      switcher_prev_r <= 1'b0;
      can_fail_prev_r <= 1'b0;
    end
    else
    begin
      switcher_prev_r <= switcher_state;
      can_fail_prev_r <= can_supply_stat | can_fault_stat;
    end
  end

  // Only 16, 24 and 32 clock transfers are legal
  assign bad_count = serial_frame_done && (serial_bit_count != 6'h10)
    && (serial_bit_count != 6'h18) && (serial_bit_count != 6'h20); // [RULE12]

  // System, supply and transceiver events
  always_comb
  begin
    sys_evt = '0;
    sys_evt[B_WDOG] = watchdog_overflow & watchdog_timeout_mode; // [RULE7]
    sys_evt[B_SERIAL] = bad_watchdog_mode_code | bad_watchdog_period_code
      | bad_op_mode_code | locked_reg_write | bad_count; // [RULE12]
    sys_evt[B_OTEMP] = overtemp_evt; // [RULE9]
    sys_evt[B_PWRON] = off_mode_exit; // [RULE11]
    sys_evt[B_OVSD] = overload_entry; // [RULE18]
    // Threshold select ignored; no event in Sleep
    sys_evt[B_MAIN_UV] = main_reg_under & ~sleep_mode; // [RULE13]
    sys_evt[B_AUX_UV] = aux_supply_under; // [RULE14]
    sys_evt[B_AUX_OV] = aux_supply_over; // [RULE15]
    sys_evt[B_BATT_UV] = batt_mon_under; // [RULE16]
    sys_evt[B_BATT_OV] = batt_mon_over; // [RULE17]
    sys_evt[B_SWITCH] = switcher_state ^ switcher_prev_r; // [RULE19]
    sys_evt[B_CAN_WAKE] = can_wake_evt & ~can_active; // [RULE4]
    sys_evt[B_CAN_FAIL] = (can_supply_stat | can_fault_stat) & ~can_fail_prev_r; // [RULE3]
    sys_evt[B_LIN_A] = lin_a_wake_evt & ~lin_a_active; // [RULE6]
    sys_evt[B_LIN_B] = lin_b_wake_evt & ~lin_b_active; // [RULE6]
    sys_evt[B_SILENCE] = can_silence_evt; // [RULE5]
    sys_evt[B_PN_ERR] = partial_net_err_evt; // [RULE10]
  end

  assign sys_en_eff = sys_enable | ALWAYS_ON_MASK; // [RULE1]
  assign ol_evt = hv_open_load_evt & hv_driver_active; // [RULE20]
  assign sc_evt = hv_short_evt & hv_driver_active; // [RULE21]
  assign re_evt = hv_rise_evt & hv_wake_input; // [RULE22]
  assign fe_evt = hv_fall_evt & hv_wake_input; // [RULE22]

  // ****************************************
  // Status flag banks
  // ****************************************
  flag_bank #(.WIDTH(SYS_FLAGS)) u_sys (
    .sys_clk(sys_clk), .rst_sync_n(rst_sync_n), .event_in(sys_evt),
    .enable_in(sys_en_eff), .clear_in(sys_clear), .flags(sys_flags));
  flag_bank #(.WIDTH(4 * NUM_HV)) u_hv (
    .sys_clk(sys_clk), .rst_sync_n(rst_sync_n),
    .event_in({ol_evt, sc_evt, re_evt, fe_evt}),
    .enable_in({hv_open_load_en, hv_short_en, hv_rise_en, hv_fall_en}),
    .clear_in({hv_open_load_clear, hv_short_clear, hv_rise_clear, hv_fall_clear}),
    .flags({ol_flags, sc_flags, re_flags, fe_flags}));

  // ****************************************
  // Pin logic and delay timer
  // ****************************************
  logic any_pending, crit_pending, any_clear, dly_running;
  logic wd_reset_nxt;

  assign any_pending = (sys_flags != '0) | (ol_flags != '0) | (sc_flags != '0)
    | (re_flags != '0) | (fe_flags != '0);
  assign crit_pending = (sys_flags & CRITICAL_MASK) != '0;
  assign any_clear = (sys_clear != '0) | (hv_open_load_clear != '0)
    | (hv_short_clear != '0) | (hv_rise_clear != '0) | (hv_fall_clear != '0);
  assign wd_reset_nxt = watchdog_overflow & watchdog_timeout_mode & sys_flags[B_WDOG]; // [RULE8]

  int_delay_timer #(.DELAY_CYC(DELAY_CYC)) u_dly (
    .sys_clk(sys_clk), .rst_sync_n(rst_sync_n), .start(any_clear),
    .stop(~reset_out_n), .running(dly_running));

  // Output registers
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_out_all_n <= 1'b1;
      irq_out_critical_n <= 1'b1;
      can_rx_pin_low <= 1'b0;
      lin_a_rx_pin_low <= 1'b0;
      lin_b_rx_pin_low <= 1'b0;
      watchdog_reset_req <= 1'b0;
      wake_req <= 1'b0;
      sys_flags_out <= FLAGS_RESET;
      hv_pin_open_load_flag <= '0;
      hv_pin_short_flag <= '0;
      hv_pin_rise_flag <= '0;
      hv_pin_fall_flag <= '0;
    end
    else
    begin
      irq_out_all_n <= ~(any_pending & ~dly_running & ~any_clear); // [RULE24] [RULE25]
      irq_out_critical_n <= ~crit_pending; // [RULE24] [RULE9]
      can_rx_pin_low <= sys_flags[B_CAN_WAKE]; // [RULE2]
      lin_a_rx_pin_low <= sys_flags[B_LIN_A]; // [RULE2]
      lin_b_rx_pin_low <= sys_flags[B_LIN_B]; // [RULE2]
      watchdog_reset_req <= wd_reset_nxt; // [RULE8]
      wake_req <= any_pending & low_power_mode; // [RULE26]
      sys_flags_out <= sys_flags;
      hv_pin_open_load_flag <= ol_flags;
      hv_pin_short_flag <= sc_flags;
      hv_pin_rise_flag <= re_flags;
      hv_pin_fall_flag <= fe_flags;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Enabled CAN wake outside Active mode
  sequence s_can_wake;
    can_wake_evt && !can_active && sys_enable[B_CAN_WAKE];
  endsequence
  sequence s_rx_held;
    can_rx_pin_low [*2];
  endsequence

  chk_can_rx_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE2]
    s_can_wake ##1 !sys_clear[B_CAN_WAKE] |=> s_rx_held)
    else $error("can receive pin not held low after wake");
  chk_rx_release: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE2]
    (sys_clear[B_CAN_WAKE] && !(can_wake_evt && !can_active && sys_enable[B_CAN_WAKE]))
      |=> ##1 !can_rx_pin_low)
    else $error("can receive pin held after flag clear");
  chk_always_on: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE1] [RULE7]
    (watchdog_overflow && watchdog_timeout_mode && sys_enable == '0)
      |=> sys_flags[B_WDOG])
    else $error("watchdog flag masked");
  chk_pwron_flag: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE11]
    off_mode_exit |=> sys_flags[B_PWRON])
    else $error("power-on flag not latched");
  chk_wd_reset: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE8]
    (sys_flags[B_WDOG] && watchdog_overflow && watchdog_timeout_mode)
      |=> watchdog_reset_req)
    else $error("second overflow gave no reset");
  chk_crit_pin: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE9]
    (overtemp_evt && sys_enable[B_OTEMP]) |=> ##1 !irq_out_critical_n)
    else $error("critical pin not asserted on overtemperature");
  chk_ovsd_crit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE18]
    overload_entry |=> ##1 !irq_out_critical_n)
    else $error("critical pin not asserted on overvoltage shutdown");
  chk_serial_count: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE12]
    (serial_frame_done && serial_bit_count == 6'h14 && sys_enable[B_SERIAL])
      |=> sys_flags[B_SERIAL])
    else $error("bad clock count not flagged");
  chk_main_sleep: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE13]
    (sleep_mode && !sys_flags[B_MAIN_UV]) |=> !sys_flags[B_MAIN_UV])
    else $error("main undervoltage flagged in sleep");
  chk_pins_release: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE24]
    !any_pending |=> irq_out_all_n && irq_out_critical_n)
    else $error("interrupt pin low with nothing pending");
  chk_clear_release: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE25]
    (any_clear && reset_out_n) |=> irq_out_all_n [*2])
    else $error("first pin not released after clear");
  chk_switch_chg: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE19]
    ($changed(switcher_state) && sys_enable[B_SWITCH]) |=> ##1 sys_flags[B_SWITCH])
    else $error("switcher change not flagged");
  chk_wake_req: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [RULE26]
    (any_pending && low_power_mode) |=> wake_req)
    else $error("no wake request in low power mode");
endmodule

//--- verification/host_mcu_model.sv
/*
  Host model: clears pending system flags by write-one, on command or
  on its own after a set wait while the all-source pin is low.
  Assumes it shares sys_clk with the interrupt source logic.
*/
`timescale 1ns/1ps
module host_mcu_model
  import irq_src_pkg::*;
(
  input wire logic sys_clk,
  input wire logic irq_out_all_n,
  input wire logic [SYS_FLAGS-1:0] sys_flags_out,
  input wire logic auto_en,
  input wire logic [7:0] wait_cyc,
  input wire logic man_go,
  input wire logic [SYS_FLAGS-1:0] man_mask,
  output logic [SYS_FLAGS-1:0] sys_clear
);
  logic [7:0] cnt_r = 8'h00;
  initial sys_clear = '0;
  // Write-one strobes: one cycle on command, two cycles after a wait
  always @(posedge sys_clk)
  begin
    sys_clear <= '0;
    cnt_r <= 8'h00;
    if (man_go)
      sys_clear <= man_mask;
    else if (auto_en && !irq_out_all_n)
    begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r >= wait_cyc)
        sys_clear <= sys_flags_out;
    end
  end
endmodule

//--- verification/tb_irq_source_logic.sv
/*
  Self-checking bench for irq_source_logic: drives sources, queues
  expected status, a watcher compares them as results appear.
  Assumes the package, design files and host model are compiled.
*/
`timescale 1ns/1ps
module tb_irq_source_logic;
  import irq_src_pkg::*;
  localparam int DLY = 8;
  localparam int MAP [20] = '{11, 13, 14, 15, 0, 2, 16, 3, 1, 1, 1, 1, 4, 5, 6, 7, 8, 9, 12, 1};
  localparam logic [9:0] XM [7] = '{10'h004, 10'h008, 10'h010, 10'h020, 10'h002, 10'h000, 10'h000};
  localparam int EB [7] = '{0, 1, 2, 4, 13, 19, 19};
  localparam int BC [7] = '{16, 16, 16, 16, 16, 24, 32};
  logic sys_clk, rst_n, man_go, auto_en, wd_seen;
  logic all_n, crit_n, can_rx, lina_rx, linb_rx, wd_req, wake;
  logic [19:0] ev;
  logic [9:0] lv;
  logic [5:0] bits;
  logic [7:0] drv, wk, wait_c, hclr, ol, sh, ri, fa;
  logic [31:0] hen, hev, hv_w, hx;
  logic [SYS_FLAGS-1:0] en, man_mask, clr, flags, fx;
  logic [23:0] stat_w;
  logic [23:0] q_stat [$];
  logic [31:0] q_hv [$];
  int mismatches, compares, p, k;
  event look;
  assign stat_w = {wd_seen, wake, all_n, crit_n, can_rx, lina_rx, linb_rx, flags};
  assign hv_w = {ol, sh, ri, fa};

  irq_source_logic #(.NUM_HV(8), .DELAY_CYC(DLY)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reset_out_n(lv[9]), .low_power_mode(lv[0]),
    .sleep_mode(lv[1]), .can_active(lv[2]), .lin_a_active(lv[3]), .lin_b_active(lv[4]),
    .can_wake_evt(ev[0]), .lin_a_wake_evt(ev[1]), .lin_b_wake_evt(ev[2]),
    .can_supply_stat(ev[18]), .can_fault_stat(lv[8]), .can_silence_evt(ev[3]),
    .watchdog_overflow(ev[4]), .watchdog_timeout_mode(lv[5]), .overtemp_evt(ev[5]),
    .partial_net_err_evt(ev[6]), .off_mode_exit(ev[7]), .bad_watchdog_mode_code(ev[8]),
    .bad_watchdog_period_code(ev[9]), .bad_op_mode_code(ev[10]), .locked_reg_write(ev[11]),
    .serial_frame_done(ev[19]), .serial_bit_count(bits), .main_reg_under(ev[13]),
    .main_reg_reset_thresh(lv[6]), .aux_supply_under(ev[14]), .aux_supply_over(ev[15]),
    .batt_mon_under(ev[16]), .batt_mon_over(ev[17]), .overload_entry(ev[12]),
    .switcher_state(lv[7]), .hv_driver_active(drv), .hv_wake_input(wk),
    .hv_open_load_evt(hev[31:24]), .hv_short_evt(hev[23:16]), .hv_rise_evt(hev[15:8]),
    .hv_fall_evt(hev[7:0]), .sys_enable(en), .hv_open_load_en(hen[31:24]),
    .hv_short_en(hen[23:16]), .hv_rise_en(hen[15:8]), .hv_fall_en(hen[7:0]),
    .sys_clear(clr), .hv_open_load_clear(hclr), .hv_short_clear(hclr),
    .hv_rise_clear(hclr), .hv_fall_clear(hclr), .sys_flags_out(flags),
    .hv_pin_open_load_flag(ol), .hv_pin_short_flag(sh), .hv_pin_rise_flag(ri),
    .hv_pin_fall_flag(fa), .irq_out_all_n(all_n), .irq_out_critical_n(crit_n),
    .can_rx_pin_low(can_rx), .lin_a_rx_pin_low(lina_rx), .lin_b_rx_pin_low(linb_rx),
    .watchdog_reset_req(wd_req), .wake_req(wake));

  host_mcu_model host_u (.sys_clk(sys_clk), .irq_out_all_n(all_n), .sys_flags_out(flags),
    .auto_en(auto_en), .wait_cyc(wait_c), .man_go(man_go), .man_mask(man_mask),
    .sys_clear(clr));

  // ****************************************
  // Clock, monitors and compares
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Remembers any reset request pulse
  always @(posedge sys_clk)
    if (wd_req === 1'b1)
      wd_seen <= 1'b1;

  task automatic report(input logic [31:0] a, input logic [31:0] e);
    compares++;
    if (a !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic compare_stat(input logic [23:0] a, input logic [23:0] e);
    report({8'h00, a}, {8'h00, e});
  endtask

  task automatic compare_hv(input logic [31:0] a, input logic [31:0] e);
    report(a, e);
  endtask

  // Takes the oldest note whenever a result is due
  initial forever
  begin
    @(look);
    compare_stat(stat_w, q_stat.pop_front());
    compare_hv(hv_w, q_hv.pop_front());
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Drivers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic pulse(input logic [19:0] m, input logic [31:0] hm);
    @(posedge sys_clk);
    ev <= m;
    hev <= hm;
    @(posedge sys_clk);
    ev <= '0;
    hev <= '0;
    tick(4);
  endtask

  task automatic clr_mask(input logic [SYS_FLAGS-1:0] m);
    @(posedge sys_clk);
    man_mask <= m;
    man_go <= 1'b1;
    @(posedge sys_clk);
    man_go <= 1'b0;
  endtask

  task automatic clear_all();
    clr_mask('1);
    hclr <= '1;
    wd_seen <= 1'b0;
    @(posedge sys_clk);
    hclr <= '0;
    tick(DLY + 8);
  endtask

  // Notes expected status; t marks the delay timer holding the pin
  task automatic chk(input logic [SYS_FLAGS-1:0] f, input logic [31:0] h, input logic t,
    input logic w);
    @(negedge sys_clk);
    q_stat.push_back({w, lv[0] & (|f | |h), t | ~(|f | |h), ~|(f & CRITICAL_MASK),
      f[B_CAN_WAKE], f[B_LIN_A], f[B_LIN_B], f});
    q_hv.push_back(h);
    -> look;
    @(posedge sys_clk);
  endtask

  // Hang guard
  initial
  begin
    tick(60000);
    mismatches++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0; ev = '0; lv = 10'h220; bits = 6'h10; drv = '0; wk = '0; wait_c = '0;
    hclr = '0; hen = '0; hev = '0; en = '0; man_go = 1'b0; man_mask = '0; auto_en = 1'b0;
    wd_seen = 1'b0; mismatches = 0; compares = 0;
    void'($urandom(48304));
    tick(10);
    rst_n <= 1'b1;
    tick(5);
    chk('0, '0, 1'b0, 1'b0);
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 20; i++)
      begin
        en <= e ? '1 : '0;
        lv[6] <= 1'($urandom);
        bits <= (i == 19) ? 6'h14 : 6'h10;
        fx = (e || ALWAYS_ON_MASK[MAP[i]]) ? 17'h1 << MAP[i] : '0;
        pulse(20'h1 << i, '0);
        chk(fx, '0, 1'b0, 1'b0);
        clear_all();
        chk('0, '0, 1'b0, 1'b0);
      end
    $display("source table done");
    for (int j = 0; j < 7; j++)
    begin
      lv <= lv ^ XM[j];
      bits <= 6'(BC[j]);
      pulse(20'h1 << EB[j], '0);
      chk('0, '0, 1'b0, 1'b0);
      lv <= lv ^ XM[j];
      tick(1);
    end
    $display("qualifier refusals done");
    pulse(20'h10, '0);
    chk(17'h1, '0, 1'b0, 1'b0);
    pulse(20'h10, '0);
    chk(17'h1, '0, 1'b0, 1'b1);
    clear_all();
    $display("watchdog repeat done");
    pulse(20'h120, '0);
    chk(17'h6, '0, 1'b0, 1'b0);
    clr_mask(17'h2);
    tick(2);
    chk(17'h4, '0, 1'b1, 1'b0);
    tick(DLY + 4);
    chk(17'h4, '0, 1'b0, 1'b0);
    lv[0] <= 1'b1;
    tick(2);
    chk(17'h4, '0, 1'b0, 1'b0);
    clr_mask(17'h4);
    tick(2);
    chk('0, '0, 1'b1, 1'b0);
    lv[0] <= 1'b0;
    tick(DLY + 4);
    chk('0, '0, 1'b0, 1'b0);
    pulse(20'h120, '0);
    clr_mask(17'h2);
    lv[9] <= 1'b0;
    tick(2);
    chk(17'h4, '0, 1'b0, 1'b0);
    lv[9] <= 1'b1;
    clear_all();
    $display("delay timer done");
    for (int s = 7; s < 9; s++)
    begin
      lv[s] <= 1'b1;
      tick(4);
      chk((s == 7) ? 17'h400 : 17'h1000, '0, 1'b0, 1'b0);
      clear_all();
      lv[s] <= 1'b0;
      tick(4);
      chk((s == 7) ? 17'h400 : 17'h0, '0, 1'b0, 1'b0);
      clear_all();
    end
    $display("level changes done");
    auto_en <= 1'b1;
    for (int w = 0; w < 2; w++)
    begin
      wait_c <= w ? 8'h14 : 8'h00;
      pulse(20'h4000, '0);
      if (w)
        chk(17'h40, '0, 1'b0, 1'b0);
      tick(30);
      chk('0, '0, 1'b0, 1'b0);
    end
    auto_en <= 1'b0;
    $display("host answers done");
    repeat (24)
    begin
      p = $urandom % 8;
      k = $urandom % 4;
      drv <= 8'($urandom);
      wk <= 8'($urandom);
      hen <= $urandom;
      @(posedge sys_clk);
      hx = ((k > 1 ? drv[p] : wk[p]) && hen[k * 8 + p]) ? 32'h1 << (k * 8 + p) : '0;
      pulse('0, 32'h1 << (k * 8 + p));
      chk('0, hx, 1'b0, 1'b0);
      clear_all();
    end
    $display("pin faults and edges done");
    results();
  end
endmodule
